// ==== hdl/pwmc_channel.v ====
// Purpose: One high-speed PWM generator with output configuration and APB registers
// Assumes: Inputs synchronous to sys_clk; one time base tick per sys_clk
// Notes: Dead time delays the rising edge of each complementary output
//
// How it works
// - Center-aligned counting only when independent time base is selected.
// - Per-generator 16-bit duty value, reset zero, sets active time.
// - Phase value is offset without independent base, period with it.
// - Primary and alternate 14-bit dead times; upper bits read zero.
// - Trigger divider emits output every N+1 trigger events.
// - Pin ownership bits give each pin to PWM or to GPIO.
// - Polarity bits make each output active-low when set.
// - Pair mode selects complementary, redundant or push-pull; 11 reserved.
// - Override enables make pins follow override data bits.
// - Active current limit drives pins to limit data bits.
// - Swap exchanges high and low signals between pins.
// - Override sync aligns override data changes to the time base.
// - With lock set, I/O control writes need the unlock sequence.
// - Trigger compare matched against local time base makes trigger events.
// - Limit source select picks faults 1-4, comparators 1-4 or fault 32.
// - Limit polarity makes selected source active-low when set.
// - Limit mode enable turns current-limit handling on.
// - Fault mode selects latched, cycle-by-cycle or disabled fault.
// - Fault polarity makes selected source active-low when set.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "pwmc_defs.vh"
module pwmc_channel #(
    parameter CNT_W = 16,
    parameter DT_W = 14
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Lock strap
    input wire config_write_lock,
    // Shared time base
    input wire [CNT_W-1:0] master_count,
    input wire [CNT_W-1:0] master_period,
    // Fault and limit sources
    input wire [3:0] fault_in,
    input wire [3:0] comp_in,
    input wire fault32_in,
    // Pins
    output reg high_output,
    output reg low_output,
    output wire high_pin_owner,
    output wire low_pin_owner,
    // Converter trigger
    output reg trigger_out
);
    // Register storage
    reg [15:0] duty_cycle_reg;
    reg [15:0] phase_or_period_reg;
    reg [15:0] dead_time_reg;
    reg [15:0] alternate_dead_time_reg;
    reg [15:0] trigger_control_reg;
    reg [15:0] pin_output_control_reg;
    reg [15:0] trigger_compare_reg;
    reg [15:0] fault_limit_control_reg;
    reg [15:0] ctrl_reg;
    reg [1:0] unlock_reg;
    // Datapath state
    reg [CNT_W-1:0] count_reg;
    reg dir_down_reg;
    reg [1:0] ovr_active_reg;
    reg fault_latch_reg;
    reg [5:0] start_cnt_reg;
    reg [3:0] div_cnt_reg;
    reg [DT_W-1:0] dt_cnt_reg;
    reg raw_prev_reg;

    wire module_enable = ctrl_reg[`PWMC_CTRL_EN];
    wire independent_timebase_sel = ctrl_reg[`PWMC_CTRL_ITB];
    wire center_aligned_en = ctrl_reg[`PWMC_CTRL_CAM] & independent_timebase_sel;
    wire [15:0] duty_value = duty_cycle_reg;
    wire [15:0] phase_value = phase_or_period_reg;
    wire [DT_W-1:0] dead_time_value = dead_time_reg[DT_W-1:0];
    wire [DT_W-1:0] alt_dead_time_value = alternate_dead_time_reg[DT_W-1:0];
    wire [3:0] trigger_divider = trigger_control_reg[`PWMC_TG_DIV_HI:`PWMC_TG_DIV_LO];
    wire [5:0] trigger_start_delay = trigger_control_reg[`PWMC_TG_STRT_HI:`PWMC_TG_STRT_LO];
    wire [1:0] pair_output_mode = pin_output_control_reg[`PWMC_IO_PAIR_OUTPUT_MODE_HI:`PWMC_IO_PAIR_OUTPUT_MODE_LO];
    wire [1:0] override_value = pin_output_control_reg[`PWMC_IO_OVD_H:`PWMC_IO_OVD_L];
    wire [1:0] fault_output_value = pin_output_control_reg[`PWMC_IO_FLD_H:`PWMC_IO_FLD_L];
    wire [1:0] limit_output_value = pin_output_control_reg[`PWMC_IO_CLD_H:`PWMC_IO_CLD_L];
    wire override_sync = pin_output_control_reg[`PWMC_IO_OVERRIDE_SYNC];
    wire [4:0] limit_source_sel = fault_limit_control_reg[`PWMC_FC_LIMIT_SOURCE_SEL_HI:`PWMC_FC_LIMIT_SOURCE_SEL_LO];
    wire limit_polarity = fault_limit_control_reg[`PWMC_FC_LIMIT_POLARITY];
    wire limit_mode_en = fault_limit_control_reg[`PWMC_FC_LIMIT_MODE_EN];
    wire [4:0] fault_source_sel = fault_limit_control_reg[`PWMC_FC_FLSRC_HI:`PWMC_FC_FLSRC_LO];
    wire fault_polarity = fault_limit_control_reg[`PWMC_FC_FLPOL];
    wire [1:0] fault_behaviour = fault_limit_control_reg[`PWMC_FC_FLMOD_HI:`PWMC_FC_FLMOD_LO];

    // APB decode; always zero wait states
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd_setup = psel & ~penable & ~pwrite;
    reg addr_ok;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    wire unlocked = ~config_write_lock | (unlock_reg == 2'h2);

    // Source selection shared by fault and limit paths
    function sel_src;
        input [4:0] code;
        input [3:0] flt;
        input [3:0] cmp;
        input f32;
        begin
            if (code[4:2] == 3'h0) begin
                sel_src = flt[code[1:0]];
            end else if (code[4:2] == 3'h2) begin
                sel_src = cmp[code[1:0]];
            end else if (code == `PWMC_SRC_F32) begin
                sel_src = f32;
            end else begin
                sel_src = 1'b0; // Reserved codes never assert
            end
        end
    endfunction

    wire limit_raw = sel_src(limit_source_sel, fault_in, comp_in, fault32_in);
    wire limit_active = limit_mode_en & (limit_raw ^ limit_polarity);
    wire fault_raw = sel_src(fault_source_sel, fault_in, comp_in, fault32_in);
    wire fault_now = (fault_raw ^ fault_polarity) & (fault_behaviour != `PWMC_FMOD_OFF);
    wire fault_active = fault_now | fault_latch_reg;

    // Time base: local period when independent, else master count plus phase
    wire [CNT_W-1:0] per = independent_timebase_sel ? phase_value : master_period;
    wire [CNT_W-1:0] tb = independent_timebase_sel ? count_reg : (master_count + phase_value);
    wire cycle_start = module_enable & (tb == {CNT_W{1'b0}}) & ~dir_down_reg;
    // Local period reset by the limit source only when limit mode is off
    wire ext_reset = independent_timebase_sel & ~limit_mode_en & (limit_raw ^ limit_polarity);

    // Address check
    always @* begin
        addr_ok = 1'b1;
        if (paddr == `PWMC_OFS_DUTY) begin
            addr_ok = 1'b1;
        end else if (paddr == `PWMC_OFS_PHASE || paddr == `PWMC_OFS_DT) begin
            addr_ok = 1'b1;
        end else if (paddr == `PWMC_OFS_ALTDT || paddr == `PWMC_OFS_TRGCON) begin
            addr_ok = 1'b1;
        end else if (paddr == `PWMC_OFS_IOCTL || paddr == `PWMC_OFS_TRIGGER_COMPARE_VALUE) begin
            addr_ok = 1'b1;
        end else if (paddr == `PWMC_OFS_FLTCL || paddr == `PWMC_OFS_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr == `PWMC_OFS_UNLOCK || paddr == `PWMC_OFS_STATUS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Register writes and the unlock sequence
    always @(posedge sys_clk) begin
        if (srst) begin
            duty_cycle_reg <= 16'h0000;
            phase_or_period_reg <= 16'h0000;
            dead_time_reg <= 16'h0000;
            alternate_dead_time_reg <= 16'h0000;
            trigger_control_reg <= 16'h0000;
            pin_output_control_reg <= 16'h0000;
            trigger_compare_reg <= 16'h0000;
            fault_limit_control_reg <= `PWMC_FLTCL_RESET;
            ctrl_reg <= 16'h0000;
            unlock_reg <= 2'h0;
        end else if (apb_wr) begin
            if (paddr == `PWMC_OFS_DUTY) begin
                duty_cycle_reg <= pwdata[15:0];
            end else if (paddr == `PWMC_OFS_PHASE) begin
                phase_or_period_reg <= pwdata[15:0];
            end else if (paddr == `PWMC_OFS_DT) begin
                dead_time_reg <= pwdata[15:0] & `PWMC_DT_MASK;
            end else if (paddr == `PWMC_OFS_ALTDT) begin
                alternate_dead_time_reg <= pwdata[15:0] & `PWMC_DT_MASK;
            end else if (paddr == `PWMC_OFS_TRGCON) begin
                trigger_control_reg <= pwdata[15:0] & `PWMC_TRGCON_MASK;
            end else if (paddr == `PWMC_OFS_IOCTL) begin
                if (unlocked) begin
                    pin_output_control_reg <= pwdata[15:0];
                end
                unlock_reg <= 2'h0; // One write per unlock
            end else if (paddr == `PWMC_OFS_TRIGGER_COMPARE_VALUE) begin
                trigger_compare_reg <= pwdata[15:0];
            end else if (paddr == `PWMC_OFS_FLTCL) begin
                fault_limit_control_reg <= pwdata[15:0] & `PWMC_FLTCL_MASK;
            end else if (paddr == `PWMC_OFS_CTRL) begin
                ctrl_reg <= pwdata[15:0] & `PWMC_CTRL_MASK;
            end else if (paddr == `PWMC_OFS_UNLOCK) begin
                // Two keys in order; any other value restarts
                if (pwdata[15:0] == `PWMC_UNLOCK_KEY1) begin
                    unlock_reg <= 2'h1;
                end else if (pwdata[15:0] == `PWMC_UNLOCK_KEY2 && unlock_reg == 2'h1) begin
                    unlock_reg <= 2'h2;
                end else begin
                    unlock_reg <= 2'h0;
                end
            end
        end
    end

    // Read data registered in the setup cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (apb_rd_setup) begin
            if (paddr == `PWMC_OFS_DUTY) begin
                prdata <= {16'h0000, duty_cycle_reg};
            end else if (paddr == `PWMC_OFS_PHASE) begin
                prdata <= {16'h0000, phase_or_period_reg};
            end else if (paddr == `PWMC_OFS_DT) begin
                prdata <= {16'h0000, dead_time_reg};
            end else if (paddr == `PWMC_OFS_ALTDT) begin
                prdata <= {16'h0000, alternate_dead_time_reg};
            end else if (paddr == `PWMC_OFS_TRGCON) begin
                prdata <= {16'h0000, trigger_control_reg};
            end else if (paddr == `PWMC_OFS_IOCTL) begin
                prdata <= {16'h0000, pin_output_control_reg};
            end else if (paddr == `PWMC_OFS_TRIGGER_COMPARE_VALUE) begin
                prdata <= {16'h0000, trigger_compare_reg};
            end else if (paddr == `PWMC_OFS_FLTCL) begin
                prdata <= {16'h0000, fault_limit_control_reg};
            end else if (paddr == `PWMC_OFS_CTRL) begin
                prdata <= {16'h0000, ctrl_reg};
            end else if (paddr == `PWMC_OFS_UNLOCK) begin
                prdata <= {30'h00000000, unlock_reg};
            end else if (paddr == `PWMC_OFS_STATUS) begin
                prdata <= {28'h0000000, limit_active, fault_active, fault_latch_reg, dir_down_reg};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Local counter, edge or center aligned
    always @(posedge sys_clk) begin
        if (srst || !module_enable) begin
            count_reg <= {CNT_W{1'b0}};
            dir_down_reg <= 1'b0;
        end else if (ext_reset) begin
            count_reg <= {CNT_W{1'b0}};
            dir_down_reg <= 1'b0;
        end else if (center_aligned_en) begin
            if (!dir_down_reg && count_reg >= per) begin
                dir_down_reg <= 1'b1;
                count_reg <= count_reg - 1'b1;
            end else if (dir_down_reg && count_reg == {CNT_W{1'b0}}) begin
                dir_down_reg <= 1'b0;
                count_reg <= count_reg + 1'b1;
            end else if (dir_down_reg) begin
                count_reg <= count_reg - 1'b1;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end else if (count_reg >= per) begin
            count_reg <= {CNT_W{1'b0}};
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Raw waveform and dead-time selection by direction of edge
    wire raw = module_enable & (tb < duty_value);
    wire rise = raw & ~raw_prev_reg;
    wire fall = ~raw & raw_prev_reg;
    wire dt_busy = (dt_cnt_reg != {DT_W{1'b0}});
    always @(posedge sys_clk) begin
        if (srst) begin
            raw_prev_reg <= 1'b0;
            dt_cnt_reg <= {DT_W{1'b0}};
        end else begin
            raw_prev_reg <= raw;
            if (rise) begin
                dt_cnt_reg <= dead_time_value;
            end else if (fall) begin
                dt_cnt_reg <= alt_dead_time_value;
            end else if (dt_busy) begin
                dt_cnt_reg <= dt_cnt_reg - 1'b1;
            end
        end
    end

    // Pair mode shaping
    reg gen_h;
    reg gen_l;
    always @* begin
        gen_h = raw;
        gen_l = ~raw;
        case (pair_output_mode)
            `PWMC_PAIR_OUTPUT_MODE_COMP: begin
                gen_h = raw & ~dt_busy & ~rise;
                gen_l = ~raw & ~dt_busy & ~fall & module_enable;
            end
            `PWMC_PAIR_OUTPUT_MODE_RED: begin
                gen_h = raw;
                gen_l = raw;
            end
            `PWMC_PAIR_OUTPUT_MODE_PP: begin
                gen_h = raw & ~dir_down_reg;
                gen_l = raw & dir_down_reg;
            end
            default: begin
                gen_h = 1'b0;
                gen_l = 1'b0;
            end
        endcase
    end

    // Override data takes effect at cycle start or at once
    always @(posedge sys_clk) begin
        if (srst) begin
            ovr_active_reg <= 2'h0;
        end else if (!override_sync || cycle_start || !module_enable) begin
            ovr_active_reg <= override_value;
        end
    end

    // Fault latch clears at a cycle start once the source is quiet
    always @(posedge sys_clk) begin
        if (srst) begin
            fault_latch_reg <= 1'b0;
        end else if (fault_now && fault_behaviour == `PWMC_FMOD_LATCH) begin
            fault_latch_reg <= 1'b1;
        end else if (cycle_start || fault_behaviour != `PWMC_FMOD_LATCH) begin
            fault_latch_reg <= 1'b0;
        end
    end

    // Output priority, then polarity and swap
    reg sel_h;
    reg sel_l;
    always @* begin
        sel_h = gen_h;
        sel_l = gen_l;
        if (fault_active) begin
            sel_h = fault_output_value[1];
            sel_l = fault_output_value[0];
        end else if (limit_active) begin
            sel_h = limit_output_value[1];
            sel_l = limit_output_value[0];
        end else begin
            if (pin_output_control_reg[`PWMC_IO_OVRH]) begin
                sel_h = ovr_active_reg[1];
            end
            if (pin_output_control_reg[`PWMC_IO_OVRL]) begin
                sel_l = ovr_active_reg[0];
            end
        end
    end
    wire pol_h = sel_h ^ pin_output_control_reg[`PWMC_IO_HIGH_PIN_POLARITY];
    wire pol_l = sel_l ^ pin_output_control_reg[`PWMC_IO_POLL];
    wire swap = pin_output_control_reg[`PWMC_IO_SWAP];
    assign high_pin_owner = pin_output_control_reg[`PWMC_IO_HIGH_PIN_OWNER];
    assign low_pin_owner = pin_output_control_reg[`PWMC_IO_LOW_PIN_OWNER];
    always @(posedge sys_clk) begin
        if (srst) begin
            high_output <= 1'b0;
            low_output <= 1'b0;
        end else begin
            high_output <= high_pin_owner & (swap ? pol_l : pol_h);
            low_output <= low_pin_owner & (swap ? pol_h : pol_l);
        end
    end

    // Trigger compare, start delay and output divider
    wire trig_event = module_enable & independent_timebase_sel
        & (count_reg == trigger_compare_reg) & ~dir_down_reg;
    always @(posedge sys_clk) begin
        if (srst || !module_enable) begin
            start_cnt_reg <= 6'h00;
            div_cnt_reg <= 4'h0;
            trigger_out <= 1'b0;
        end else begin
            trigger_out <= 1'b0;
            if (cycle_start && start_cnt_reg < trigger_start_delay) begin
                start_cnt_reg <= start_cnt_reg + 6'h01;
            end
            if (trig_event && start_cnt_reg >= trigger_start_delay) begin
                if (div_cnt_reg >= trigger_divider) begin
                    div_cnt_reg <= 4'h0;
                    trigger_out <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule

// ==== hdl/pwmc_defs.vh ====
// Purpose: Constants for the PWM channel output configuration block
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: Offsets other than the printed registers are local choices
`ifndef PWMC_DEFS_VH
`define PWMC_DEFS_VH
`define PWMC_OFS_DUTY 12'h000
`define PWMC_OFS_PHASE 12'h004
`define PWMC_OFS_DT 12'h008
`define PWMC_OFS_ALTDT 12'h00C
`define PWMC_OFS_TRGCON 12'h010
`define PWMC_OFS_IOCTL 12'h014
`define PWMC_OFS_TRIGGER_COMPARE_VALUE 12'h018
`define PWMC_OFS_FLTCL 12'h01C
`define PWMC_OFS_CTRL 12'h020
`define PWMC_OFS_UNLOCK 12'h024
`define PWMC_OFS_STATUS 12'h028
`define PWMC_UNLOCK_KEY1 16'h5555
`define PWMC_UNLOCK_KEY2 16'hAAAA
`define PWMC_FLTCL_RESET 16'h00F8
`define PWMC_DT_MASK 16'h3FFF
`define PWMC_TRGCON_MASK 16'hF03F
`define PWMC_FLTCL_MASK 16'h7FFF
`define PWMC_CTRL_MASK 16'h0007
// Control register bits
`define PWMC_CTRL_EN 0
`define PWMC_CTRL_ITB 1
`define PWMC_CTRL_CAM 2
// I/O control fields
`define PWMC_IO_HIGH_PIN_OWNER 15
`define PWMC_IO_LOW_PIN_OWNER 14
`define PWMC_IO_HIGH_PIN_POLARITY 13
`define PWMC_IO_POLL 12
`define PWMC_IO_PAIR_OUTPUT_MODE_HI 11
`define PWMC_IO_PAIR_OUTPUT_MODE_LO 10
`define PWMC_IO_OVRH 9
`define PWMC_IO_OVRL 8
`define PWMC_IO_OVD_H 7
`define PWMC_IO_OVD_L 6
`define PWMC_IO_FLD_H 5
`define PWMC_IO_FLD_L 4
`define PWMC_IO_CLD_H 3
`define PWMC_IO_CLD_L 2
`define PWMC_IO_SWAP 1
`define PWMC_IO_OVERRIDE_SYNC 0
// Fault and limit fields
`define PWMC_FC_LIMIT_SOURCE_SEL_HI 14
`define PWMC_FC_LIMIT_SOURCE_SEL_LO 10
`define PWMC_FC_LIMIT_POLARITY 9
`define PWMC_FC_LIMIT_MODE_EN 8
`define PWMC_FC_FLSRC_HI 7
`define PWMC_FC_FLSRC_LO 3
`define PWMC_FC_FLPOL 2
`define PWMC_FC_FLMOD_HI 1
`define PWMC_FC_FLMOD_LO 0
// Trigger fields
`define PWMC_TG_DIV_HI 15
`define PWMC_TG_DIV_LO 12
`define PWMC_TG_STRT_HI 5
`define PWMC_TG_STRT_LO 0
// Modes
`define PWMC_PAIR_OUTPUT_MODE_COMP 2'h0
`define PWMC_PAIR_OUTPUT_MODE_RED 2'h1
`define PWMC_PAIR_OUTPUT_MODE_PP 2'h2
`define PWMC_FMOD_LATCH 2'h0
`define PWMC_FMOD_CYCLE 2'h1
`define PWMC_FMOD_OFF 2'h3
`define PWMC_SRC_CMP_BASE 5'h08
`define PWMC_SRC_F32 5'h1F
`endif

// ==== tb/pwm_channel_output_config_tb.sv ====
// Purpose: Self-checking bench for the PWM channel
// Assumes: Zero-wait APB slave; the bench runs the shared time base
// Notes: Pins are judged three edges after each cause to cover sense lag
`timescale 1ns/10ps
`include "pwmc_defs.vh"
module pwm_channel_output_config_tb;
    // Bench-driven inputs
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic config_write_lock = 1'b0;
    logic [15:0] master_count = 16'h0000;
    logic fault32_in = 1'b0;
    logic overcurrent = 1'b0;
    // Outputs and bench state
    wire pready, pslverr, high_output, low_output, high_pin_owner, low_pin_owner, trigger_out;
    wire [31:0] prdata;
    wire [3:0] fault_in, comp_in;
    logic [31:0] rdata;
    logic err;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    // Shared base wraps every 20 ticks so latched faults can clear
    always @(posedge sys_clk) begin
        master_count <= (master_count == 16'h0013) ? 16'h0000 : master_count + 16'h0001;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    pwmc_channel u_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .config_write_lock(config_write_lock), .master_count(master_count),
        .master_period(16'h0013), .fault_in(fault_in), .comp_in(comp_in),
        .fault32_in(fault32_in), .high_output(high_output), .low_output(low_output),
        .high_pin_owner(high_pin_owner), .low_pin_owner(low_pin_owner),
        .trigger_out(trigger_out));
    pwmc_stage u_stage (.sys_clk(sys_clk), .high_output(high_output),
        .low_output(low_output), .overcurrent(overcurrent), .fault_in(fault_in),
        .comp_in(comp_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the idle edge at the end keeps strobes from merging
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a stalled access
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic pins(input logic h, input logic l);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, high_output, low_output}, {30'h0, h, l});
    endtask
    // Spacing of two trigger pulses, zero if fewer than two come
    task automatic gap(output int g);
        int first;
        first = -1;
        g = 0;
        for (int t = 0; t < 200 && g == 0; t++) begin
            @(posedge sys_clk);
            if (trigger_out === 1'b1 && first >= 0) g = t - first;
            if (trigger_out === 1'b1 && first < 0) first = t;
        end
    endtask
    task automatic t_regs();
        logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h018, 12'h01C};
        logic [15:0] msk [7] = '{16'hFFFF, 16'hFFFF, 16'h3FFF, 16'h3FFF, 16'hF03F, 16'hFFFF, 16'h7FFF};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rdata, (i == 6) ? 32'h00F8 : 32'h0);
            apb(1'b1, ofs[i], 32'hFFFFFFFF);
            apb(1'b0, ofs[i], 32'h0);
            chk(rdata, {16'h0, msk[i]});
        end
        apb(1'b1, 12'h030, 32'h1);
        chk({31'h0, err}, 32'h1);
    endtask
    // Module stays disabled while override, polarity, swap, limit and fault are set
    task automatic t_pins();
        apb(1'b1, `PWMC_OFS_FLTCL, 32'h01F8);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'hC380);
        pins(1'b1, 1'b0);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'hC382);
        pins(1'b0, 1'b1);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'hF380);
        pins(1'b0, 1'b1);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'hC3A4);
        overcurrent <= 1'b1;
        pins(1'b0, 1'b1);
        fault32_in <= 1'b1;
        pins(1'b1, 1'b0);
        fault32_in <= 1'b0;
        repeat (50) @(posedge sys_clk);
        pins(1'b1, 1'b0);
        // No cycle starts while disabled, so cycle mode releases the latch
        apb(1'b1, `PWMC_OFS_FLTCL, 32'h01F9);
        pins(1'b0, 1'b1);
        overcurrent <= 1'b0;
        pins(1'b1, 1'b0);
        apb(1'b1, `PWMC_OFS_FLTCL, 32'h03F8);
        pins(1'b0, 1'b1);
        apb(1'b1, `PWMC_OFS_FLTCL, 32'h02F8);
        pins(1'b1, 1'b0);
    endtask
    task automatic t_lock();
        config_write_lock <= 1'b1;
        apb(1'b1, `PWMC_OFS_IOCTL, 32'h0);
        apb(1'b0, `PWMC_OFS_IOCTL, 32'h0);
        chk(rdata, 32'hC3A4);
        apb(1'b1, `PWMC_OFS_UNLOCK, 32'h5555);
        apb(1'b1, `PWMC_OFS_UNLOCK, 32'hAAAA);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'h0);
        apb(1'b0, `PWMC_OFS_IOCTL, 32'h0);
        chk(rdata, 32'h0);
        pins(1'b0, 1'b0);
        config_write_lock <= 1'b0;
    endtask
    task automatic t_trig();
        int g1;
        int g4;
        // Limit mode off and source quiet, so no external period reset
        apb(1'b1, `PWMC_OFS_FLTCL, 32'h00F8);
        apb(1'b1, `PWMC_OFS_TRGCON, 32'h0);
        apb(1'b1, `PWMC_OFS_PHASE, 32'h9);
        apb(1'b1, `PWMC_OFS_TRIGGER_COMPARE_VALUE, 32'h2);
        apb(1'b1, `PWMC_OFS_CTRL, 32'h1);
        gap(g1);
        chk(g1, 32'h0);
        apb(1'b1, `PWMC_OFS_CTRL, 32'h3);
        gap(g1);
        chk(g1, 32'hA);
        apb(1'b1, `PWMC_OFS_TRGCON, 32'h3000);
        gap(g4);
        chk(g4, 4 * g1);
    endtask
    // Redundant pair at full duty drives both pins; complementary would not
    task automatic t_mode();
        apb(1'b1, `PWMC_OFS_CTRL, 32'h0);
        apb(1'b1, `PWMC_OFS_IOCTL, 32'hC400);
        apb(1'b1, `PWMC_OFS_CTRL, 32'h3);
        pins(1'b1, 1'b1);
    endtask
    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_pins();
        t_lock();
        t_trig();
        t_mode();
        conclude();
    end
endmodule
bind pwmc_channel pwmc_checker u_chk (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .config_write_lock(config_write_lock), .high_output(high_output),
    .low_output(low_output), .high_pin_owner(high_pin_owner),
    .low_pin_owner(low_pin_owner), .trigger_out(trigger_out));

// ==== tb/pwmc_checker.sv ====
// Purpose: Port checks for the PWM channel
// Assumes: Zero-wait APB, read data registered at setup
// Notes: Pin data needs register state, so the bench judges it
`timescale 1ns/10ps
`include "pwmc_defs.vh"
module pwmc_checker (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire config_write_lock,
    // Pins
    input wire high_output,
    input wire low_output,
    input wire high_pin_owner,
    input wire low_pin_owner,
    input wire trigger_out
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // Read setup and unlocked pin control write
    wire rd = psel && !penable && !pwrite;
    wire io_wr = psel && penable && pwrite && paddr == `PWMC_OFS_IOCTL && !config_write_lock;
    a_unmapped_err: assert property (psel && penable && paddr > `PWMC_OFS_STATUS |-> pslverr)
        else $error("no error on unmapped address");
    a_read_upper: assert property (rd |=> prdata[31:16] == 16'h0000)
        else $error("upper read half set");
    a_dead_width: assert property (rd && paddr[11:3] == 9'h001 |=> prdata[15:14] == 2'h0)
        else $error("dead time top bits set");
    a_trg_gap: assert property (rd && paddr == `PWMC_OFS_TRGCON |=> prdata[11:6] == 6'h00)
        else $error("trigger gap bits set");
    a_limit_top: assert property (rd && paddr == `PWMC_OFS_FLTCL |=> !prdata[15])
        else $error("limit bit 15 set");
    a_owner_write: assert property (io_wr |=> {high_pin_owner, low_pin_owner} == $past(pwdata[15:14]))
        else $error("owner bits wrong");
    a_high_free: assert property (!$past(high_pin_owner) |-> !high_output)
        else $error("high pin driven unowned");
    a_low_free: assert property (!$past(low_pin_owner) |-> !low_output)
        else $error("low pin driven unowned");
    c_trig: cover property (trigger_out);
    c_err: cover property (pslverr);
    c_pin: cover property (high_output && low_pin_owner);
endmodule

// ==== tb/pwmc_stage.sv ====
// Purpose: Power stage model behind the high and low pins
// Assumes: Sense lines are levels synchronous to sys_clk
// Notes: Overcurrent is commanded by the bench, not derived from a load
`timescale 1ns/10ps
module pwmc_stage (
    // Clock
    input wire sys_clk,
    // Gate drive
    input wire high_output,
    input wire low_output,
    // Sense command and sense lines
    input wire overcurrent,
    output logic [3:0] fault_in = 4'h0,
    output logic [3:0] comp_in = 4'h0
);
    // Sense registered, since a real comparator lags the bridge
    always @(posedge sys_clk) begin
        fault_in <= {3'h0, overcurrent};
        comp_in <= {3'h0, high_output & low_output}; // Shoot-through sense
    end
endmodule
